// >>> hw/quhp_pkg.sv
// shared constants and types of the four channel host port
package quhp_pkg;

  localparam int CHANS  = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // register offsets inside one channel
  localparam logic [ADDR_W-1:0] ADR_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_IER  = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_ISR  = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_LCR  = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_MCR  = 3'h4;
  localparam logic [ADDR_W-1:0] ADR_LSR  = 3'h5;
  localparam logic [ADDR_W-1:0] ADR_MSR  = 3'h6;
  localparam logic [ADDR_W-1:0] ADR_SPR  = 3'h7;

  // reset values and access keys
  localparam logic [DATA_W-1:0] REG_RST      = 8'h00;
  localparam logic [DATA_W-1:0] DLL_RST      = 8'h01;
  localparam logic [DATA_W-1:0] LCR_FEAT_KEY = 8'hBF;

  // field positions
  localparam int LCR_DLAB_BIT  = 7;
  localparam int FCR_FIFO_BIT  = 0;
  localparam int FCR_BLOCK_BIT = 3;
  localparam int IER_RX_BIT    = 0;
  localparam int IER_TX_BIT    = 1;

  // interrupt identification codes
  localparam logic [3:0] ISR_NONE     = 4'h1;
  localparam logic [3:0] ISR_RX       = 4'h4;
  localparam logic [3:0] ISR_TX       = 4'h2;
  localparam logic [1:0] ISR_FIFO_ON  = 2'h3;
  localparam logic [1:0] ISR_FIFO_OFF = 2'h0;
  localparam logic [1:0] ISR_PAD      = 2'h0;
  localparam logic       LSR_PAD      = 1'b0;

  // reset pin pulse qualification
  localparam int RST_MIN_NS    = 40;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_MIN_RAW   = (RST_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int RST_MIN_CYC   = (RST_MIN_RAW < 1) ? 1 : RST_MIN_RAW;
  localparam logic [3:0] RST_MIN_CNT = 4'(RST_MIN_CYC);

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } quhp_bus_e;

  // status word delivered by one channel's serial side
  typedef struct packed {
    logic [DATA_W-1:0] rx_byte;
    logic [DATA_W-1:0] modem_status_reg;
    logic              rx_nonempty;
    logic              rx_at_trig;
    logic              rx_timeout;
    logic              tx_empty;
    logic              tx_full;
    logic              tx_above_trig;
    logic              tsr_empty;
  } quhp_stat_s;

  typedef struct packed {
    logic fifo_en;
    logic block_mode;
    logic ier_rx;
    logic ier_tx;
  } quhp_cfg_s;

endpackage : quhp_pkg

// >>> hw/quhp_chan_rdy.sv
// per channel interrupt, ready pins and line status bits
`timescale 1ns/1ps
module quhp_chan_rdy
  import quhp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        chan_rst,
  // configuration and status
  input  wire quhp_cfg_s   cfg,
  input  wire quhp_stat_s  stat,
  // results
  output logic             int_o,
  output logic             rx_rdy_n,
  output logic             tx_rdy_n,
  output logic             rx_c,
  output logic             tx_c,
  output logic [DATA_W-1:0] line_status_reg
);

  wire blk      = cfg.fifo_en && cfg.block_mode;
  wire tx_room  = cfg.fifo_en ? !stat.tx_full : stat.tx_empty;
  wire rx_fall  = stat.rx_at_trig || stat.rx_timeout;

  // single-character fifo mode falls back to the empty flag
  assign tx_c = blk ? !stat.tx_above_trig : stat.tx_empty;
  assign rx_c = cfg.fifo_en ? stat.rx_at_trig
                            : stat.rx_nonempty;
  assign line_status_reg  = {LSR_PAD, stat.tx_empty && stat.tsr_empty, tx_room,
                 4'h0, stat.rx_nonempty};

  wire nxt_int  = (cfg.ier_rx && rx_c) || (cfg.ier_tx && tx_c);
  // block mode: fall wins over rise so a trigger is never lost
  wire nxt_rx_n = !blk ? !stat.rx_nonempty
                : rx_fall ? 1'b0
                : !stat.rx_nonempty ? 1'b1 : rx_rdy_n;
  wire nxt_tx_n = blk ? stat.tx_full : !stat.tx_empty;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_o    <= 1'b0;
      rx_rdy_n <= 1'b1;
      tx_rdy_n <= 1'b1;
    end
    else if (ce)
    begin
      int_o    <= chan_rst ? 1'b0 : nxt_int;
      rx_rdy_n <= chan_rst ? 1'b1 : nxt_rx_n;
      tx_rdy_n <= chan_rst ? 1'b1 : nxt_tx_n;
    end
  end

  property p_rx_block_hold;
    @(posedge clk) disable iff (rst)
      ce && !chan_rst && blk && !rx_rdy_n && stat.rx_nonempty
      |=> !rx_rdy_n;
  endproperty
  a_rx_block_hold: assert property (p_rx_block_hold)
    else $error("rx ready rose before fifo emptied");

  property p_tx_block_full;
    @(posedge clk) disable iff (rst)
      ce && !chan_rst && blk |=> tx_rdy_n == $past(stat.tx_full);
  endproperty
  a_tx_block_full: assert property (p_tx_block_full)
    else $error("tx ready not tracking fifo full");

  property p_rx_single;
    @(posedge clk) disable iff (rst)
      ce && !chan_rst && !blk && stat.rx_nonempty |=> !rx_rdy_n;
  endproperty
  a_rx_single: assert property (p_rx_single)
    else $error("rx ready high while byte held");

  property p_tx_int_off;
    @(posedge clk) disable iff (rst)
      ce && !chan_rst && !cfg.fifo_en && cfg.ier_tx && stat.tx_empty
      |=> int_o;
  endproperty
  a_tx_int_off: assert property (p_tx_int_off)
    else $error("interrupt low with empty holding register");

  c_block_fall: cover property (@(posedge clk) disable iff (rst)
    blk && rx_rdy_n ##1 !rx_rdy_n);

endmodule : quhp_chan_rdy

// >>> hw/quhp_top.sv
// four channel asynchronous serial controller host port
//   Contract
// - eight data lines, three register address lines, read and write strobes
// - bus cycles framed by select and strobe levels sampled on SYS_CLK rising edges while CLK_EN is high
// - one shared data bus, driven only by the selected channel
// - strobe style: high reset pulse over 40 ns resets every channel
// - select style: low reset pulse of 40 ns does the same
// - style pin high picks strobe style, low picks select style
// - strobe style: a low select picks its channel, all low picks all
// - select style: chip select low, upper lines 00..11 pick A..D
// - upper decode lines ignored in strobe style
// - each channel owns full standard register set
// - each channel owns feature and two flow character registers
// - block mode: transmit interrupt low above trigger, else high
// - receive interrupt: one byte with fifo off, at trigger with fifo on
// - with fifo on, block bit chooses single-character or block ready behaviour
// - line status bits 5 and 6 report room and transmitter empty
// - receive ready low while a byte is held outside block mode
// - block mode receive ready falls at trigger or timeout, rises on empty
// - transmit ready low on empty holding register or empty fifo
// - block mode transmit ready low with a free slot, high when full
// - one clock shared by channels and bus logic, bus sampled on its rising edge
`timescale 1ns/1ps
module quhp_top
  import quhp_pkg::*;
(
  // clock and reset
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST,
  input  wire logic                     CLK_EN,
  // bus style and reset pin
  input  wire logic                     BUS_STYLE,
  input  wire logic                     RESET_PIN,
  // channel selection
  input  wire logic                     SEL_CHAN_A_N,
  input  wire logic                     SEL_CHAN_B_N,
  input  wire logic                     SEL_CHAN_C_N,
  input  wire logic                     SEL_CHAN_D_N,
  input  wire logic                     CHAN_DECODE_LO,
  input  wire logic                     CHAN_DECODE_HI,
  // strobes and address
  input  wire logic                     READ_STROBE_N,
  input  wire logic                     WRITE_STROBE_N,
  input  wire logic                     RW_SEL,
  input  wire logic [ADDR_W-1:0]        ADDR,
  // data bus
  input  wire logic [DATA_W-1:0]        DATA_IN,
  output logic      [DATA_W-1:0]        DATA_OUT,
  output logic                          DATA_OE,
  // serial side status and strobes
  input  wire quhp_stat_s [CHANS-1:0]   CHAN_STAT,
  output logic      [CHANS-1:0]         TX_PUSH,
  output logic      [DATA_W-1:0]        TX_BYTE,
  output logic      [CHANS-1:0]         RX_POP,
  output quhp_cfg_s [CHANS-1:0]         CHAN_CFG,
  output logic                          CHAN_RST,
  // per channel pins
  output logic      [CHANS-1:0]         INT_OUT,
  output logic      [CHANS-1:0]         RX_READY_N,
  output logic      [CHANS-1:0]         TX_READY_N
);

  quhp_bus_e                state_ff;
  quhp_bus_e                nxt_state;
  logic [CHANS-1:0]         sel_ff;
  logic [ADDR_W-1:0]        adr_ff;
  logic [DATA_W-1:0]        wd_ff;
  logic [3:0]               rst_cnt_ff;
  logic                     chan_rst_ff;
  logic [DATA_W-1:0]        dout_ff;
  logic                     oe_ff;
  logic [CHANS-1:0]         push_ff;
  logic [CHANS-1:0]         pop_ff;
  logic [DATA_W-1:0]        tx_byte_ff;
  quhp_stat_s [CHANS-1:0]   stat_ff;
  logic [DATA_W-1:0]        rdv [CHANS];
  logic [CHANS-1:0]         push_w;
  logic [CHANS-1:0]         pop_w;
  logic [CHANS-1:0]         dll_is_rst;

  // channel selection in both bus styles
  wire [CHANS-1:0] strobe_sel = ~{SEL_CHAN_D_N, SEL_CHAN_C_N,
                                  SEL_CHAN_B_N, SEL_CHAN_A_N};
  wire [1:0]       dec_idx    = {CHAN_DECODE_HI, CHAN_DECODE_LO};
  wire [CHANS-1:0] rw_sel_vec = SEL_CHAN_A_N ? 4'h0
                              : 4'(4'h1 << dec_idx);
  wire [CHANS-1:0] live_sel   = BUS_STYLE ? strobe_sel
                                          : rw_sel_vec;
  wire             cs_any     = |live_sel;

  wire rd_req = BUS_STYLE ? cs_any && !READ_STROBE_N
                          : cs_any && RW_SEL;
  wire wr_req = BUS_STYLE ? cs_any && !WRITE_STROBE_N
                          : cs_any && !RW_SEL;

  // a read of several channels returns the lowest one only
  wire [1:0] rd_idx = live_sel[0] ? 2'h0 : live_sel[1] ? 2'h1
                    : live_sel[2] ? 2'h2 : 2'h3;

  wire wr_commit = (state_ff == BUS_WRITE) && !wr_req;
  wire rd_done   = (state_ff == BUS_READ) && !rd_req;

  // reset pin polarity follows the bus style
  wire pin_act   = BUS_STYLE ? RESET_PIN : !RESET_PIN;
  wire [3:0] rst_inc = (rst_cnt_ff == 4'hF) ? rst_cnt_ff
                                            : 4'(rst_cnt_ff + 4'h1);
  wire [3:0] nxt_rst_cnt = pin_act ? rst_inc : 4'h0;
  wire nxt_chan_rst = pin_act && (rst_inc >= RST_MIN_CNT);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      BUS_IDLE:
      begin
        if (rd_req)
          nxt_state = BUS_READ;
        else if (wr_req)
          nxt_state = BUS_WRITE;
      end
      BUS_READ:
      begin
        if (!rd_req)
          nxt_state = BUS_IDLE;
      end
      BUS_WRITE:
      begin
        if (!wr_req)
          nxt_state = BUS_IDLE;
      end
      default:
        nxt_state = BUS_IDLE;
    endcase
  end

  // cycle framed by select and strobe levels sampled on the clock edge
  wire capture = (state_ff == BUS_IDLE) && (rd_req || wr_req);
  wire [DATA_W-1:0] nxt_wd = wr_req ? DATA_IN : wd_ff;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_ff    <= BUS_IDLE;
      sel_ff      <= 4'h0;
      adr_ff      <= ADR_DATA;
      wd_ff       <= REG_RST;
      rst_cnt_ff  <= 4'h0;
      chan_rst_ff <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_ff    <= nxt_state;
      sel_ff      <= capture ? live_sel : sel_ff;
      adr_ff      <= capture ? ADDR : adr_ff;
      wd_ff       <= nxt_wd;
      rst_cnt_ff  <= nxt_rst_cnt;
      chan_rst_ff <= nxt_chan_rst;
    end
  end

  // serial status sampled as whole words; the bus never waits on it
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      stat_ff <= '0;
    else if (CLK_EN)
      stat_ff <= CHAN_STAT;
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      dout_ff    <= REG_RST;
      oe_ff      <= 1'b0;
      push_ff    <= 4'h0;
      pop_ff     <= 4'h0;
      tx_byte_ff <= REG_RST;
    end
    else if (CLK_EN)
    begin
      dout_ff    <= rd_req ? rdv[rd_idx] : dout_ff;
      oe_ff      <= rd_req;
      push_ff    <= push_w;
      pop_ff     <= pop_w;
      tx_byte_ff <= wr_commit ? wd_ff : tx_byte_ff;
    end
  end

  genvar i;
  generate
    for (i = 0; i < CHANS; i++)
    begin : chan_g
      logic [DATA_W-1:0] ier_ff, fcr_ff, lcr_ff, mcr_ff, spr_ff;
      logic [DATA_W-1:0] dll_ff, dlm_ff, dld_ff;
      logic [DATA_W-1:0] efr_ff, xon1_ff, xon2_ff;
      logic [DATA_W-1:0] line_status_reg;
      logic              rx_c;
      logic              tx_c;

      wire dlab  = lcr_ff[LCR_DLAB_BIT];
      wire feat  = (lcr_ff == LCR_FEAT_KEY);
      // broadcast writes land in every selected channel
      wire we    = wr_commit && sel_ff[i];
      wire a_dat = (adr_ff == ADR_DATA);
      wire a_ier = (adr_ff == ADR_IER);
      wire a_isr = (adr_ff == ADR_ISR);
      wire a_mcr = (adr_ff == ADR_MCR);
      wire a_lsr = (adr_ff == ADR_LSR);

      wire we_dll  = we && a_dat && dlab;
      wire we_dlm  = we && a_ier && dlab;
      wire we_ier  = we && a_ier && !dlab;
      wire we_efr  = we && a_isr && feat;
      wire we_dld  = we && a_isr && dlab && !feat;
      wire we_fcr  = we && a_isr && !dlab;
      wire we_lcr  = we && (adr_ff == ADR_LCR);
      wire we_xon1 = we && a_mcr && feat;
      wire we_mcr  = we && a_mcr && !feat;
      wire we_xon2 = we && a_lsr && feat;
      wire we_spr  = we && (adr_ff == ADR_SPR);

      assign push_w[i] = we && a_dat && !dlab;
      assign pop_w[i]  = rd_done && sel_ff[i] && a_dat && !dlab;

      always_ff @(posedge SYS_CLK or posedge RST)
      begin
        if (RST)
        begin
          {ier_ff, fcr_ff, lcr_ff, mcr_ff, spr_ff} <= '0;
          {dlm_ff, dld_ff, efr_ff, xon1_ff, xon2_ff} <= '0;
          dll_ff <= DLL_RST;
        end
        else if (CLK_EN && chan_rst_ff)
        begin
          {ier_ff, fcr_ff, lcr_ff, mcr_ff, spr_ff} <= '0;
          {dlm_ff, dld_ff, efr_ff, xon1_ff, xon2_ff} <= '0;
          dll_ff <= DLL_RST;
        end
        else if (CLK_EN)
        begin
          if (we_dll)  dll_ff  <= wd_ff;
          if (we_dlm)  dlm_ff  <= wd_ff;
          if (we_dld)  dld_ff  <= wd_ff;
          if (we_ier)  ier_ff  <= wd_ff;
          if (we_fcr)  fcr_ff  <= wd_ff;
          if (we_lcr)  lcr_ff  <= wd_ff;
          if (we_mcr)  mcr_ff  <= wd_ff;
          if (we_spr)  spr_ff  <= wd_ff;
          if (we_efr)  efr_ff  <= wd_ff;
          if (we_xon1) xon1_ff <= wd_ff;
          if (we_xon2) xon2_ff <= wd_ff;
        end
      end

      assign CHAN_CFG[i].fifo_en    = fcr_ff[FCR_FIFO_BIT];
      assign CHAN_CFG[i].block_mode = fcr_ff[FCR_BLOCK_BIT];
      assign CHAN_CFG[i].ier_rx     = ier_ff[IER_RX_BIT];
      assign CHAN_CFG[i].ier_tx     = ier_ff[IER_TX_BIT];

      wire rx_i = CHAN_CFG[i].ier_rx && rx_c;
      wire tx_i = CHAN_CFG[i].ier_tx && tx_c;
      wire [DATA_W-1:0] irq_status_reg = {CHAN_CFG[i].fifo_en ? ISR_FIFO_ON
                                                   : ISR_FIFO_OFF,
                               ISR_PAD,
                               rx_i ? ISR_RX : tx_i ? ISR_TX : ISR_NONE};

      assign rdv[i] = a_dat ? (dlab ? dll_ff : stat_ff[i].rx_byte)
                    : a_ier ? (dlab ? dlm_ff : ier_ff)
                    : a_isr ? (feat ? efr_ff : dlab ? dld_ff : irq_status_reg)
                    : (adr_ff == ADR_LCR) ? lcr_ff
                    : a_mcr ? (feat ? xon1_ff : mcr_ff)
                    : a_lsr ? (feat ? xon2_ff : line_status_reg)
                    : (adr_ff == ADR_MSR) ? stat_ff[i].modem_status_reg
                    : spr_ff;
      assign dll_is_rst[i] = (dll_ff == DLL_RST);

      quhp_chan_rdy u_rdy (
        .clk      (SYS_CLK),
        .rst      (RST),
        .ce       (CLK_EN),
        .chan_rst (chan_rst_ff),
        .cfg      (CHAN_CFG[i]),
        .stat     (stat_ff[i]),
        .int_o    (INT_OUT[i]),
        .rx_rdy_n (RX_READY_N[i]),
        .tx_rdy_n (TX_READY_N[i]),
        .rx_c     (rx_c),
        .tx_c     (tx_c),
        .line_status_reg      (line_status_reg)
      );
    end
  endgenerate

  // read mux uses the address captured at the strobe's first edge, so
  // the first data cycle is stale and a mid-strobe address change is lost
  assign DATA_OUT = dout_ff;
  assign DATA_OE  = oe_ff;
  assign TX_PUSH  = push_ff;
  assign TX_BYTE  = tx_byte_ff;
  assign RX_POP   = pop_ff;
  assign CHAN_RST = chan_rst_ff;

  property p_oe_read;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && rd_req |=> DATA_OE;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("bus not driven during read");

  property p_oe_quiet;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && !rd_req |=> !DATA_OE;
  endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("bus driven outside read");

  property p_strobe_sel;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && BUS_STYLE && capture
      |=> sel_ff == $past(strobe_sel);
  endproperty
  a_strobe_sel: assert property (p_strobe_sel)
    else $error("strobe style selection wrong");

  property p_rw_sel;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && !BUS_STYLE && capture
      |=> sel_ff == 4'(4'h1 << $past(dec_idx));
  endproperty
  a_rw_sel: assert property (p_rw_sel)
    else $error("select style decode wrong");

  property p_write_ends;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && wr_commit |=> state_ff == BUS_IDLE;
  endproperty
  a_write_ends: assert property (p_write_ends)
    else $error("write cycle did not close on strobe release");

  property p_tx_push;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && wr_commit && sel_ff[0] && adr_ff == ADR_DATA
      && !chan_g[0].dlab |=> TX_PUSH[0] && TX_BYTE == $past(wd_ff);
  endproperty
  a_tx_push: assert property (p_tx_push)
    else $error("holding write not pushed whole");

  property p_pin_reset;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && chan_rst_ff |=> dll_is_rst == 4'hF;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("divisor not restored by reset pin");

  property p_pin_pol;
    @(posedge SYS_CLK) disable iff (RST)
      CLK_EN && !BUS_STYLE && RESET_PIN |=> !CHAN_RST;
  endproperty
  a_pin_pol: assert property (p_pin_pol)
    else $error("select style reset acted on high level");

  c_read:  cover property (@(posedge SYS_CLK) disable iff (RST)
    state_ff == BUS_READ ##1 state_ff == BUS_IDLE);
  c_bcast: cover property (@(posedge SYS_CLK) disable iff (RST)
    wr_commit && sel_ff == 4'hF);

endmodule : quhp_top

// >>> verification/quhp_host_model.sv
// host processor model that drives the asynchronous register bus
`timescale 1ns/1ps
module quhp_host_model
  import quhp_pkg::*;
(
  // clock and bus style
  input  wire logic              clk,
  input  wire logic              style,
  // bus lines, eight data and three address lines
  output logic [CHANS-1:0]       sel_n,
  output logic [1:0]             dec,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic                   rw_sel,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      wdata,
  // read data from the device
  input  wire logic [DATA_W-1:0] rdata
);
  initial
  begin
    sel_n  = 4'hF;
    dec    = 2'h0;
    rd_n   = 1'b1;
    wr_n   = 1'b1;
    rw_sel = 1'b1;
    addr   = 3'h0;
    wdata  = 8'h00;
  end

  // all four selected only in strobe style, decode lines noise there
  task automatic start(input int ch, input logic all);
    sel_n = style ? (all ? 4'h0 : ~(4'h1 << ch)) : 4'hE;
    dec   = style ? 2'($urandom) : 2'(ch);
  endtask : start

  // released data lines flip so a stale byte is never read as valid
  task automatic release_bus;
    sel_n  = 4'hF;
    rd_n   = 1'b1;
    wr_n   = 1'b1;
    rw_sel = 1'b1;
    wdata  = ~wdata;
    @(negedge clk);
  endtask : release_bus

  task automatic wr(input int ch, input logic all,
                    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    start(ch, all);
    addr   = a;
    wdata  = d;
    rw_sel = 1'b0;
    wr_n   = ~style;
    repeat (2) @(posedge clk);
    @(negedge clk);
    release_bus();
  endtask : wr

  // never more than one channel selected for a read
  task automatic rd(input int ch, input logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d);
    @(negedge clk);
    start(ch, 1'b0);
    addr   = a;
    rw_sel = 1'b1;
    rd_n   = ~style;
    repeat (2) @(posedge clk);
    @(negedge clk);
    d = rdata;
    release_bus();
  endtask : rd
endmodule : quhp_host_model

// >>> verification/quhp_top_test.sv
// self-checking bench of the four channel host port
`timescale 1ns/1ps
module quhp_top_test
  import quhp_pkg::*;
;
  localparam int SW = $bits(quhp_stat_s);
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   style = 1'b1;
  logic                   pin_act = 1'b0;
  logic                   ce = 1'b1;
  wire logic              reset_pin = style ? pin_act : ~pin_act;
  logic [CHANS-1:0]       sel_n;
  logic [1:0]             dec;
  logic                   rd_n, wr_n, rw_sel, oe, chan_rst;
  logic [ADDR_W-1:0]      addr;
  logic [DATA_W-1:0]      wdata, rdata, tx_byte, rv, lv;
  quhp_stat_s [CHANS-1:0] stat = '0;
  quhp_cfg_s  [CHANS-1:0] cfg;
  logic [CHANS-1:0]       int_out, rxr_n, txr_n, rx_hold;
  logic [CHANS-1:0]       tx_push, rx_pop;
  logic [1:0]             ie [CHANS];
  logic [DATA_W-1:0]      scr [CHANS];
  logic [2:0]             ex;
  int                     fails = 0;
  int                     compares = 0;

  always #20 sys_clk = ~sys_clk;

  quhp_host_model quhp_host_model_i (.clk(sys_clk), .style(style),
    .sel_n(sel_n), .dec(dec), .rd_n(rd_n), .wr_n(wr_n), .rw_sel(rw_sel),
    .addr(addr), .wdata(wdata), .rdata(rdata));

  quhp_top quhp_top_i (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(ce),
    .BUS_STYLE(style), .RESET_PIN(reset_pin), .SEL_CHAN_A_N(sel_n[0]),
    .SEL_CHAN_B_N(sel_n[1]), .SEL_CHAN_C_N(sel_n[2]),
    .SEL_CHAN_D_N(sel_n[3]), .CHAN_DECODE_LO(dec[0]),
    .CHAN_DECODE_HI(dec[1]), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .RW_SEL(rw_sel), .ADDR(addr), .DATA_IN(wdata), .DATA_OUT(rdata),
    .DATA_OE(oe), .CHAN_STAT(stat), .TX_PUSH(tx_push), .TX_BYTE(tx_byte),
    .RX_POP(rx_pop), .CHAN_CFG(cfg), .CHAN_RST(chan_rst), .INT_OUT(int_out),
    .RX_READY_N(rxr_n), .TX_READY_N(txr_n));

  task automatic chk_byte(input string what, input logic [DATA_W-1:0] e,
                          input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte

  task automatic chk_pin(input string what, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask : chk_pin

  task automatic rd_chk(input int ch, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e, input string what);
    logic [DATA_W-1:0] d;
    quhp_host_model_i.rd(ch, a, d);
    chk_byte(what, e, d);
  endtask : rd_chk

  // block mode receive ready keeps its level between trigger and empty
  function automatic logic [2:0] exp_pins(input quhp_stat_s s,
    input logic f, input logic b, input logic [1:0] irq_enable_reg, input logic hold);
    logic blk, rxc, txc, rxr;
    blk = f & b;
    rxc = f ? s.rx_at_trig : s.rx_nonempty;
    txc = blk ? !s.tx_above_trig : s.tx_empty;
    rxr = !blk ? !s.rx_nonempty : (s.rx_at_trig | s.rx_timeout) ? 1'b0 :
          !s.rx_nonempty ? 1'b1 : hold;
    return {irq_enable_reg[0] & rxc | irq_enable_reg[1] & txc, rxr, blk ? s.tx_full : !s.tx_empty};
  endfunction : exp_pins

  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    void'($urandom(13));
    fork
      begin
        #400000;
        fails++;
        finish_test();
      end
    join_none
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int c = 0; c < CHANS; c++)
    begin
      quhp_host_model_i.wr(c, 1'b0, ADR_LCR, 8'h80);
      rd_chk(c, ADR_DATA, DLL_RST, "divisor low");
      rd_chk(c, ADR_IER, REG_RST, "divisor high");
      quhp_host_model_i.wr(c, 1'b0, ADR_LCR, REG_RST);
      rv = 8'($urandom);
      quhp_host_model_i.wr(c, 1'b0, ADR_DATA, rv);
      chk_byte("tx byte", rv, tx_byte);
      chk_pin("tx push", 1'b1, tx_push[c]);
      rd_chk(c, ADR_DATA, REG_RST, "rx byte");
      chk_pin("rx pop", 1'b1, rx_pop[c]);
      scr[c] = 8'($urandom);
      quhp_host_model_i.wr(c, 1'b0, ADR_SPR, scr[c]);
    end
    quhp_host_model_i.wr(1, 1'b0, ADR_LCR, LCR_FEAT_KEY);
    rv = 8'($urandom);
    quhp_host_model_i.wr(1, 1'b0, ADR_ISR, rv);
    rd_chk(1, ADR_ISR, rv, "feature");
    quhp_host_model_i.wr(1, 1'b0, ADR_LCR, REG_RST);
    for (int s = 1; s >= 0; s--)
    begin
      style = s[0];
      for (int c = 0; c < CHANS; c++)
        rd_chk(c, ADR_SPR, scr[c], "scratch");
    end
    style = 1'b1;
    rv = 8'($urandom);
    quhp_host_model_i.wr(0, 1'b1, ADR_SPR, rv);
    for (int c = 0; c < CHANS; c++)
      rd_chk(c, ADR_SPR, rv, "broadcast");
    chk_pin("bus drive", 1'b0, oe);
    // a frozen clock enable must not let the reset pin qualify
    ce = 1'b0;
    pin_act = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_pin("frozen reset", 1'b0, chan_rst);
    pin_act = 1'b0;
    ce = 1'b1;
    @(negedge sys_clk);
    for (int s = 1; s >= 0; s--)
    begin
      style = s[0];
      quhp_host_model_i.wr(3, 1'b0, ADR_SPR, 8'h5A);
      pin_act = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_pin("channel reset", 1'b1, chan_rst);
      pin_act = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd_chk(3, ADR_SPR, REG_RST, "pin reset");
    end
    style = 1'b1;
    // modes: fifo off, single character, block
    for (int m = 0; m < 3; m++)
    begin
      stat = '0;
      rx_hold = '1;
      for (int c = 0; c < CHANS; c++)
      begin
        ie[c] = 2'($urandom);
        quhp_host_model_i.wr(c, 1'b0, ADR_ISR, {4'h0, m == 2, 2'h0, m > 0});
        quhp_host_model_i.wr(c, 1'b0, ADR_IER, {6'h00, ie[c]});
      end
      for (int i = 0; i < 30; i++)
      begin
        for (int c = 0; c < CHANS; c++)
          stat[c] = quhp_stat_s'(SW'($urandom));
        repeat (3) @(negedge sys_clk);
        for (int c = 0; c < CHANS; c++)
        begin
          ex = exp_pins(stat[c], m > 0, m == 2, ie[c], rx_hold[c]);
          rx_hold[c] = ex[1];
          chk_pin("interrupt", ex[2], int_out[c]);
          chk_pin("rx ready", ex[1], rxr_n[c]);
          chk_pin("tx ready", ex[0], txr_n[c]);
          chk_pin("block bit", m == 2, cfg[c].block_mode);
        end
        lv = {LSR_PAD, stat[i%4].tx_empty & stat[i%4].tsr_empty,
              m > 0 ? !stat[i%4].tx_full : stat[i%4].tx_empty, 4'h0,
              stat[i%4].rx_nonempty};
        rd_chk(i % 4, ADR_LSR, lv, "line status");
      end
    end
    finish_test();
  end
endmodule : quhp_top_test
